// >>> verilog/crt_timer.sv
// Capture/reload timer with an AXI4-Lite register slave
`timescale 1ns/100ps
`include "crt_consts.svh"

module crt_timer
#(
    parameter int WIDTH = 16
)
(
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        count_input_pin,
    input  wire logic        trigger_pin,
    output logic             rx_baud_tick,
    output logic             tx_baud_tick,
    output logic             irq
);
    typedef struct packed {
        crt_pkg::crt_control_t ctrl;
        logic [WIDTH-1:0]      reload;
        logic [WIDTH-1:0]      count;
        logic                  prescale;
        logic [1:0]            irq_status;
        logic [1:0]            irq_mask;
        logic                  aw_held;
        logic [7:0]            aw_addr;
        logic                  w_held;
        logic [7:0]            w_data;
        logic                  w_strb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
        logic                  rx_tick;
        logic                  tx_tick;
        logic                  irq;
    } crt_state_t;

    crt_state_t          st;
    crt_state_t          next_st;
    crt_pkg::crt_edges_t edges;

    crt_pin_edges u_pin_edges
    (
        .clock           (clock),
        .reset           (reset),
        .count_input_pin (count_input_pin),
        .trigger_pin     (trigger_pin),
        .edges           (edges)
    );

    logic baud_mode;
    logic step;
    logic overflow;
    logic trig_act;
    logic do_write;
    logic do_read;
    logic [7:0] wr_byte;

    assign baud_mode = st.ctrl.rx_sel | st.ctrl.tx_sel;
    assign do_write  = st.aw_held && st.w_held && !st.bvalid;
    assign do_read   = s_axi_arvalid && !st.rvalid;
    assign wr_byte   = st.w_data;

    always_comb
    begin
        next_st = st;
        // Timer mode steps on alternate clocks; counter mode on pin edges
        if (!st.ctrl.src)
            step = st.ctrl.run && st.prescale;
        else
            step = st.ctrl.run && edges.count_fall;
        overflow = step && (st.count == {WIDTH{1'b1}});
        trig_act = edges.trig_fall && st.ctrl.pin_en && !baud_mode;
        next_st.prescale = (st.ctrl.run && !st.ctrl.src) ? ~st.prescale : 1'b0;

        if (step)
            next_st.count = st.count + 1'b1;
        if (overflow && (baud_mode || !st.ctrl.capt))
            next_st.count = st.reload;
        if (trig_act && !st.ctrl.capt)
            next_st.count = st.reload;
        if (trig_act && st.ctrl.capt)
            next_st.reload = st.count;

        next_st.rx_tick = overflow && st.ctrl.rx_sel;
        next_st.tx_tick = overflow && st.ctrl.tx_sel;

        // Bus side: address and data may arrive in either order
        next_st.aw_held = st.aw_held | s_axi_awvalid;
        if (s_axi_awvalid && !st.aw_held)
            next_st.aw_addr = s_axi_awaddr;
        next_st.w_held = st.w_held | s_axi_wvalid;
        if (s_axi_wvalid && !st.w_held)
        begin
            next_st.w_data  = s_axi_wdata[7:0];
            next_st.w_strb0 = s_axi_wstrb[0];
        end
        if (st.bvalid && s_axi_bready)
            next_st.bvalid = 1'b0;

        if (do_write)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = `CRT_RESP_OKAY;
            if (st.aw_addr == `CRT_OFS_CONTROL)
            begin
                if (st.w_strb0)
                    next_st.ctrl = wr_byte;
            end
            else if (st.aw_addr == `CRT_OFS_RELOAD_LOW)
            begin
                if (st.w_strb0)
                    next_st.reload[7:0] = wr_byte;
            end
            else if (st.aw_addr == `CRT_OFS_RELOAD_HIGH)
            begin
                if (st.w_strb0)
                    next_st.reload[15:8] = wr_byte;
            end
            else if (st.aw_addr == `CRT_OFS_COUNT_LOW)
            begin
                if (st.w_strb0)
                    next_st.count[7:0] = wr_byte;
            end
            else if (st.aw_addr == `CRT_OFS_COUNT_HIGH)
            begin
                if (st.w_strb0)
                    next_st.count[15:8] = wr_byte;
            end
            else if (st.aw_addr == `CRT_OFS_IRQ_MASK)
            begin
                if (st.w_strb0)
                    next_st.irq_mask = wr_byte[1:0];
            end
            else if (st.aw_addr != `CRT_OFS_IRQ_STATUS)
                next_st.bresp = `CRT_RESP_SLVERR;
        end

        if (st.rvalid && s_axi_rready)
            next_st.rvalid = 1'b0;
        if (do_read)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = `CRT_RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            if (s_axi_araddr == `CRT_OFS_CONTROL)
                next_st.rdata[7:0] = st.ctrl;
            else if (s_axi_araddr == `CRT_OFS_RELOAD_LOW)
                next_st.rdata[7:0] = st.reload[7:0];
            else if (s_axi_araddr == `CRT_OFS_RELOAD_HIGH)
                next_st.rdata[7:0] = st.reload[15:8];
            else if (s_axi_araddr == `CRT_OFS_COUNT_LOW)
                next_st.rdata[7:0] = st.count[7:0];
            else if (s_axi_araddr == `CRT_OFS_COUNT_HIGH)
                next_st.rdata[7:0] = st.count[15:8];
            else if (s_axi_araddr == `CRT_OFS_IRQ_STATUS)
            begin
                next_st.rdata[1:0] = st.irq_status;
                next_st.irq_status = 2'b00;
            end
            else if (s_axi_araddr == `CRT_OFS_IRQ_MASK)
                next_st.rdata[1:0] = st.irq_mask;
            else
                next_st.rresp = `CRT_RESP_SLVERR;
        end

        // Hardware sets applied last so an event beats a same-cycle clear
        if (overflow && !baud_mode)
        begin
            next_st.ctrl.ovf       = 1'b1;
            next_st.irq_status[1]  = 1'b1;
        end
        if (trig_act)
        begin
            next_st.ctrl.edge_f    = 1'b1;
            next_st.irq_status[0]  = 1'b1;
        end
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            st      <= '0;
            st.ctrl <= `CRT_RST_CONTROL;
        end
        else
            st <= next_st;
    end

    // Each channel is ready only while it holds nothing latched; each channel buffered once
    always_comb
    begin
        s_axi_awready = !st.aw_held;
        s_axi_wready  = !st.w_held;
        s_axi_arready = !st.rvalid;
    end
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp  = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata  = st.rdata;
    assign s_axi_rresp  = st.rresp;
    assign rx_baud_tick = st.rx_tick;
    assign tx_baud_tick = st.tx_tick;
    assign irq          = st.irq;

    sequence s_trig_capture;
        trig_act && st.ctrl.capt;
    endsequence

    a_ovf_flag_set: assert property (@(posedge clock) disable iff (reset)
        (overflow && !baud_mode) |=> st.ctrl.ovf)
        else $error("overflow flag not set");
    a_ovf_flag_quiet: assert property (@(posedge clock) disable iff (reset)
        (baud_mode && !st.ctrl.ovf && !do_write) |=> !st.ctrl.ovf)
        else $error("overflow flag set in baud mode");
    a_edge_flag_set: assert property (@(posedge clock) disable iff (reset)
        trig_act |=> st.ctrl.edge_f)
        else $error("edge flag not set");
    a_rx_tick_src: assert property (@(posedge clock) disable iff (reset)
        rx_baud_tick |-> $past(overflow) && $past(st.ctrl.rx_sel))
        else $error("receive tick without overflow");
    a_tx_tick_src: assert property (@(posedge clock) disable iff (reset)
        (overflow && st.ctrl.tx_sel) |=> tx_baud_tick)
        else $error("transmit tick missing");
    a_trig_gated: assert property (@(posedge clock) disable iff (reset)
        trig_act |-> (st.ctrl.pin_en && !st.ctrl.rx_sel && !st.ctrl.tx_sel))
        else $error("trigger acted while gated");
    a_timer_rate: assert property (@(posedge clock) disable iff (reset)
        (st.ctrl.run && !st.ctrl.src && step && !overflow && !trig_act && !do_write)
        |=> !step)
        else $error("timer stepped on consecutive clocks");
    a_stopped_hold: assert property (@(posedge clock) disable iff (reset)
        (!st.ctrl.run && !trig_act && !do_write) |=> $stable(st.count))
        else $error("count moved while stopped");
    a_counter_edge: assert property (@(posedge clock) disable iff (reset)
        (st.ctrl.src && step) |-> edges.count_fall)
        else $error("counter stepped without pin edge");
    a_reload_ovf: assert property (@(posedge clock) disable iff (reset)
        (overflow && !st.ctrl.capt && !do_write) |=> st.count == $past(st.reload))
        else $error("no reload on overflow");
    a_capture: assert property (@(posedge clock) disable iff (reset)
        s_trig_capture |=> st.reload == $past(st.count))
        else $error("capture did not copy count");
    a_baud_reload: assert property (@(posedge clock) disable iff (reset)
        (overflow && baud_mode && !do_write) |=> st.count == $past(st.reload))
        else $error("baud mode did not reload");
endmodule : crt_timer

// >>> include/crt_consts.svh
// Register offsets, field positions and reset values of the capture/reload timer
`ifndef CRT_CONSTS_SVH
`define CRT_CONSTS_SVH
`define CRT_OFS_CONTROL      8'hc8
`define CRT_OFS_RELOAD_LOW   8'hca
`define CRT_OFS_RELOAD_HIGH  8'hcb
`define CRT_OFS_COUNT_LOW    8'hcc
`define CRT_OFS_COUNT_HIGH   8'hcd
`define CRT_OFS_IRQ_STATUS   8'hd0
`define CRT_OFS_IRQ_MASK     8'hd4
`define CRT_BIT_OVF          7
`define CRT_BIT_EDGE         6
`define CRT_BIT_RX_SEL       5
`define CRT_BIT_TX_SEL       4
`define CRT_BIT_PIN_EN       3
`define CRT_BIT_RUN          2
`define CRT_BIT_SRC          1
`define CRT_BIT_CAPT         0
`define CRT_RST_CONTROL      8'h00
`define CRT_RST_BYTE         8'h00
`define CRT_RST_SYNC         8'hfc
`define CRT_TIMER_DIV        2
`define CRT_RESP_OKAY        2'b00
`define CRT_RESP_SLVERR      2'b10
`endif

// >>> include/crt_pkg.sv
// Types shared by the capture/reload timer files
package crt_pkg;
    typedef struct packed {
        logic ovf;
        logic edge_f;
        logic rx_sel;
        logic tx_sel;
        logic pin_en;
        logic run;
        logic src;
        logic capt;
    } crt_control_t;

    typedef struct packed {
        logic count_fall;
        logic trig_fall;
    } crt_edges_t;

    typedef struct packed {
        logic count_meta;
        logic count_sync;
        logic count_prev;
        logic trig_meta;
        logic trig_sync;
        logic trig_prev;
        logic count_fall;
        logic trig_fall;
    } crt_sync_state_t;
endpackage : crt_pkg

// >>> verilog/crt_pin_edges.sv
// Two-flop synchronisers and falling-edge detectors for the count and trigger pins
`timescale 1ns/100ps
`include "crt_consts.svh"
module crt_pin_edges
(
    input  wire logic                clock,
    input  wire logic                reset,
    input  wire logic                count_input_pin,
    input  wire logic                trigger_pin,
    output crt_pkg::crt_edges_t      edges
);
    crt_pkg::crt_sync_state_t st;
    crt_pkg::crt_sync_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.count_meta = count_input_pin;
        next_st.count_sync = st.count_meta;
        next_st.count_prev = st.count_sync;
        next_st.trig_meta  = trigger_pin;
        next_st.trig_sync  = st.trig_meta;
        next_st.trig_prev  = st.trig_sync;
        // Only synchronised samples feed the comparison
        next_st.count_fall = st.count_prev & ~st.count_sync;
        next_st.trig_fall  = st.trig_prev & ~st.trig_sync;
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
            // Samples start at the idle-high level so reset gives no false edge
            st <= `CRT_RST_SYNC;
        else
            st <= next_st;
    end

    assign edges.count_fall = st.count_fall;
    assign edges.trig_fall  = st.trig_fall;

    a_edge_pulse: assert property (@(posedge clock) disable iff (reset)
        (st.count_prev && !st.count_sync) |=> edges.count_fall)
        else $error("count pin falling edge missed");
endmodule : crt_pin_edges

// >>> bench/crt_pin_model.sv
// Model of the external count and trigger pins and of the serial port's baud inputs
`timescale 1ns/100ps
module crt_pin_model
(
    input  wire logic clock,
    output logic      count_input_pin,
    output logic      trigger_pin,
    input  wire logic rx_baud_tick,
    input  wire logic tx_baud_tick
);
    int rx_ticks = 0;
    int tx_ticks = 0;

    initial count_input_pin = 1'b1;
    initial trigger_pin = 1'b1;

    // Serial port side: every baud pulse is one bit period
    always @(posedge clock)
    begin
        rx_ticks <= rx_ticks + int'(rx_baud_tick === 1'b1);
        tx_ticks <= tx_ticks + int'(tx_baud_tick === 1'b1);
    end

    // Pins idle high; each level lasts hold cycles so the sampler sees both
    task pulse(input bit on_trig, input int n, input int hold);
        repeat (n)
        begin
            @(posedge clock);
            if (on_trig)
                trigger_pin <= 1'b0;
            else
                count_input_pin <= 1'b0;
            repeat (hold) @(posedge clock);
            trigger_pin <= 1'b1;
            count_input_pin <= 1'b1;
            repeat (hold) @(posedge clock);
        end
    endtask : pulse
endmodule : crt_pin_model

// >>> bench/tb_top.sv
// Self-checking bench of the capture/reload timer over its register bus
`timescale 1ns/100ps
`include "crt_consts.svh"
`define CHK(what, exp, got) \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
        $display("ERROR %s expected %h seen %h", what, exp, got); \
        failures++; \
    end
module tb_top;
    logic        clock = 1'b0, reset = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        count_input_pin, trigger_pin, rx_baud_tick, tx_baud_tick, irq;
    logic [7:0]  v;
    logic [7:0]  map [7] = '{8'hc8, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hd0, 8'hd4};
    logic [7:0]  bauds [3] = '{8'h25, 8'h1d, 8'h34};
    int          failures = 0, samples_checked = 0, cycles = 0, rx0, tx0;

    crt_timer u_crt_timer (.clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin,
        .trigger_pin, .rx_baud_tick, .tx_baud_tick, .irq);
    crt_pin_model u_crt_pin_model (.clock, .count_input_pin, .trigger_pin, .rx_baud_tick,
        .tx_baud_tick);

    initial forever #2 clock = ~clock;

    task end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= {24'h0, d};
        s_axi_wstrb   <= 4'h1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        `CHK("bresp", (a == 8'hc4) ? `CRT_RESP_SLVERR : `CRT_RESP_OKAY, s_axi_bresp)
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge clock);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        v = s_axi_rdata[7:0];
        `CHK("rresp", (a == 8'hc0) ? `CRT_RESP_SLVERR : `CRT_RESP_OKAY, s_axi_rresp)
    endtask : rd

    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        `CHK($sformatf("reg_%h", a), exp, v)
    endtask : rd_chk

    task done(input string n);
        $display("test %s finished", n);
    endtask : done

    initial
    begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        foreach (map[i]) rd_chk(map[i], 8'h00);
        rd(8'hc0);
        wr(8'hc4, 8'h55);
        done("reset");
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hd4, 8'h02);
        rd_chk(8'hca, 8'h34);
        rd_chk(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        repeat (20) @(posedge clock);
        `CHK("irq", 1'b1, irq)
        rd_chk(8'hc8, 8'h84);
        rd_chk(8'hcd, 8'h12);
        rd_chk(8'hd0, 8'h02);
        rd_chk(8'hd0, 8'h00);
        `CHK("irq", 1'b0, irq)
        done("reload");
        wr(8'hc8, 8'h00);
        wr(8'hcc, 8'h00);
        wr(8'hc8, 8'h04);
        repeat (100) @(posedge clock);
        wr(8'hc8, 8'h00);
        rd(8'hcc);
        `CHK("rate", 1'b1, (v >= 8'd48 && v <= 8'd56))
        rd_chk(8'hcc, v);
        done("rate");
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h05);
        repeat (20) @(posedge clock);
        wr(8'hc8, 8'h00);
        rd_chk(8'hcd, 8'h00);
        // Capture-mode wrap is still an overflow event; clear it before the edge test
        `CHK("irq", 1'b1, irq)
        rd_chk(8'hd0, 8'h02);
        wr(8'hcc, 8'hcd);
        wr(8'hcd, 8'hab);
        wr(8'hc8, 8'h09);
        u_crt_pin_model.pulse(1'b1, 1, 2);
        repeat (8) @(posedge clock);
        rd_chk(8'hca, 8'hcd);
        rd_chk(8'hcb, 8'hab);
        rd_chk(8'hc8, 8'h49);
        `CHK("irq", 1'b0, irq)
        rd_chk(8'hd0, 8'h01);
        done("capture");
        wr(8'hc8, 8'h00);
        wr(8'hca, 8'h78);
        wr(8'hcb, 8'h56);
        wr(8'hcc, 8'h00);
        wr(8'hc8, 8'h08);
        u_crt_pin_model.pulse(1'b1, 1, 5);
        repeat (8) @(posedge clock);
        rd_chk(8'hcc, 8'h78);
        rd_chk(8'hc8, 8'h48);
        done("trigger_reload");
        wr(8'hc8, 8'h00);
        wr(8'hcc, 8'h00);
        wr(8'hc8, 8'h06);
        u_crt_pin_model.pulse(1'b0, 5, 2);
        repeat (8) @(posedge clock);
        rd_chk(8'hcc, 8'h05);
        done("counter");
        // Each baud setting also tries the trigger pin, which must stay ignored
        foreach (bauds[i])
        begin
            wr(8'hc8, 8'h00);
            wr(8'hcb, 8'h40);
            wr(8'hcc, 8'hfe);
            wr(8'hcd, 8'hff);
            rx0 = u_crt_pin_model.rx_ticks;
            tx0 = u_crt_pin_model.tx_ticks;
            wr(8'hc8, bauds[i]);
            u_crt_pin_model.pulse(1'b1, 1, 2);
            repeat (20) @(posedge clock);
            rd_chk(8'hcd, 8'h40);
            rd_chk(8'hc8, bauds[i]);
            `CHK("rx_ticks", int'(bauds[i][5]), u_crt_pin_model.rx_ticks - rx0)
            `CHK("tx_ticks", int'(bauds[i][4]), u_crt_pin_model.tx_ticks - tx0)
        end
        done("baud");
        end_of_test();
    end
endmodule : tb_top
